// ### rtl/ptl_dev_end.sv
`timescale 1ns/1ns
module ptl_dev_end
    import ptl_pkg::*;
#(
    parameter logic [9:0]  HDR_CREDITS  = HDR_CREDIT_DEF,
    parameter logic [9:0]  DATA_CREDITS = DATA_CREDIT_DEF,
    // Arbitrary value; the bus number is not known to this block.
    parameter logic [15:0] OWN_ID       = 16'h0100
)(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    ptl_link_if.dev          lnk,
    input  wire logic        nvm_done,
    input  wire logic        nvm_mps_256,
    input  wire logic        cfg_mps_256,
    output logic [3:0]       dev_port_type,
    output logic             cli_valid,
    input  wire logic        cli_ack,
    output ptl_dest_t        cli_dest,
    output ptl_kind_t        cli_kind,
    output logic [63:0]      cli_addr,
    output logic [31:0]      cli_wdata,
    input  wire logic [31:0] cli_rdata,
    input  wire logic        dma_rd_valid,
    output logic             dma_rd_ready,
    input  wire logic [63:0] dma_rd_addr,
    input  wire logic [10:0] dma_rd_len,
    input  wire logic [7:0]  dma_rd_tag,
    output logic             dma_cpl_valid,
    output logic [7:0]       dma_cpl_tag,
    output logic [31:0]      dma_cpl_data
);

    // ****************************************************************
    // State
    // ****************************************************************
    ptl_state_t  state, next_state;
    ptl_tlp_t    hold, next_hold;
    ptl_tlp_t    up_tlp, next_up_tlp;
    logic        up_valid, next_up_valid;
    logic        dn_ready, next_dn_ready;
    logic [9:0]  fc_avail [FC_N];
    logic [9:0]  next_fc_avail [FC_N];
    logic [9:0]  held [FC_N];
    logic [9:0]  next_held [FC_N];
    logic [9:0]  need [FC_N];
    logic [9:0]  take [FC_N];
    logic [9:0]  give [FC_N];
    logic [2:0]  cpl_status, next_cpl_status;
    logic [31:0] cpl_data, next_cpl_data;
    logic        cpl_has_data, next_cpl_has_data;
    logic        next_cli_valid, next_dma_rd_ready, next_dma_cpl_valid;
    ptl_dest_t   next_cli_dest;
    ptl_kind_t   next_cli_kind;
    logic [63:0] next_cli_addr;
    logic [31:0] next_cli_wdata, next_dma_cpl_data;
    logic [7:0]  next_dma_cpl_tag;
    logic [3:0]  next_dev_port_type;
    logic [1:0]  done_sync, mps_sync;
    logic        fits, over, bad_fmt, bad_len, is_cfg, is_read, is_posted, is_mem;
    logic        has_payload;
    logic [10:0] mps_dw;

    assign lnk.dn_ready = dn_ready;
    assign lnk.up_valid = up_valid;
    assign lnk.up_tlp   = up_tlp;

    // Credits needed per class; data credits are 16-byte units.
    function automatic logic [9:0] fc_need(input ptl_tlp_t t, input int cls);
        logic [9:0] dc;
        dc = 10'((t.len + DW_PER_CREDIT_M1) >> 2);
        fc_need = '0;
        case (t.kind)
            K_CFG_RD, K_MEM_RD, K_IO_RD, K_MEM_RD_LK: begin
                if (cls == FC_NPH) fc_need = ONE_CREDIT;
            end
            K_CFG_WR, K_IO_WR: begin
                if (cls == FC_NPH) fc_need = ONE_CREDIT;
                if (cls == FC_NPD) fc_need = dc;
            end
            K_MEM_WR: begin
                if (cls == FC_PH) fc_need = ONE_CREDIT;
                if (cls == FC_PD) fc_need = dc;
            end
            K_MSG: begin
                if (cls == FC_PH) fc_need = ONE_CREDIT;
            end
            K_CPL, K_CPLD: begin
                if (cls == FC_CPLH) fc_need = ONE_CREDIT;
                if (cls == FC_CPLD && t.kind == K_CPLD) fc_need = dc;
            end
            default: fc_need = '0;
        endcase
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_state         = state;
        next_hold          = hold;
        next_up_valid      = up_valid;
        next_up_tlp        = up_tlp;
        next_cpl_status    = cpl_status;
        next_cpl_data      = cpl_data;
        next_cpl_has_data  = cpl_has_data;
        next_cli_valid     = cli_valid;
        next_cli_dest      = cli_dest;
        next_cli_kind      = cli_kind;
        next_cli_addr      = cli_addr;
        next_cli_wdata     = cli_wdata;
        next_dma_cpl_valid = 1'b0;
        next_dma_cpl_tag   = dma_cpl_tag;
        next_dma_cpl_data  = dma_cpl_data;
        next_dev_port_type = dev_port_type;
        // Supported size comes from NVM, the one in force from config space.
        mps_dw      = (mps_sync[1] && cfg_mps_256) ? MPS_LARGE_DW : MPS_SMALL_DW;
        is_cfg      = hold.kind == K_CFG_RD || hold.kind == K_CFG_WR;
        is_read     = hold.kind == K_CFG_RD || hold.kind == K_MEM_RD || hold.kind == K_IO_RD;
        is_posted   = hold.kind == K_MEM_WR || hold.kind == K_MSG;
        is_mem      = hold.kind == K_MEM_RD || hold.kind == K_MEM_RD_LK
                      || hold.kind == K_MEM_WR;
        has_payload = hold.kind == K_MEM_WR || hold.kind == K_CPLD
                      || hold.kind == K_CFG_WR || hold.kind == K_IO_WR;
        bad_fmt     = is_mem && (hold.hdr4 != (|hold.addr[63:32]));
        bad_len     = has_payload && (hold.len > mps_dw);
        fits        = 1'b1;
        over        = 1'b0;
        for (int i = 0; i < FC_N; i++) begin
            need[i]      = fc_need(hold, i);
            take[i]      = '0;
            give[i]      = '0;
            next_held[i] = held[i];
            if (need[i] > fc_avail[i]) fits = 1'b0;
            if (need[i] > ((i % 2 == 0) ? HDR_CREDITS : DATA_CREDITS)) over = 1'b1;
        end
        if (up_valid && lnk.up_ready) next_up_valid = 1'b0;

        case (state)
            S_IDLE: begin
                if (lnk.dn_valid && dn_ready) begin
                    next_hold  = lnk.dn_tlp;
                    next_state = S_CHECK;
                end
            end
            S_CHECK: begin
                // The digest bit is neither checked nor acted on.
                if (bad_fmt || bad_len || over) begin
                    next_state = S_IDLE;
                end else if (fits) begin
                    take      = need;
                    next_held = need;
                    next_state = S_CLIENT;
                    next_cli_valid = 1'b1;
                    next_cli_kind  = hold.kind;
                    next_cli_addr  = hold.addr;
                    next_cli_wdata = hold.data;
                    next_cli_dest  = is_cfg ? D_CFG : D_CSR;
                    next_cpl_has_data = is_read;
                    if (hold.kind == K_CPL || hold.kind == K_CPLD) begin
                        next_cli_valid     = 1'b0;
                        next_dma_cpl_valid = 1'b1;
                        next_dma_cpl_tag   = hold.tag;
                        next_dma_cpl_data  = hold.data;
                        give       = need;
                        next_state = S_IDLE;
                    end else if (is_posted && hold.tc != TC_ZERO) begin
                        next_cli_valid = 1'b0;
                        give       = need;
                        next_state = S_IDLE;
                    end else if (hold.kind == K_MSG) begin
                        next_cli_dest  = D_MSG;
                        next_cli_wdata = {24'h000000, hold.code};
                    end else if (is_cfg && !done_sync[1]) begin
                        next_cli_valid    = 1'b0;
                        next_cpl_status   = CPL_CRS;
                        next_cpl_has_data = 1'b0;
                        next_state        = S_CPL;
                    end else if (hold.kind == K_MEM_RD_LK || hold.tc != TC_ZERO
                                 || (is_read && hold.len > MAX_RD_DW)) begin
                        next_cli_valid    = 1'b0;
                        next_cpl_status   = CPL_UR;
                        next_cpl_has_data = 1'b0;
                        next_state        = S_CPL;
                    end
                end
            end
            S_CLIENT: begin
                if (cli_ack) begin
                    next_cli_valid = 1'b0;
                    if (is_posted) begin
                        give       = held;
                        next_state = S_IDLE;
                    end else begin
                        next_cpl_status = CPL_SC;
                        next_cpl_data   = cli_rdata;
                        next_state      = S_CPL;
                    end
                end
            end
            S_CPL: begin
                if (!up_valid) begin
                    next_up_valid      = 1'b1;
                    next_up_tlp        = '0;
                    next_up_tlp.kind   = cpl_has_data ? K_CPLD : K_CPL;
                    next_up_tlp.len    = cpl_has_data ? 11'h001 : 11'h000;
                    next_up_tlp.rid    = hold.rid;
                    next_up_tlp.tag    = hold.tag;
                    next_up_tlp.attr   = hold.attr;
                    next_up_tlp.status = cpl_status;
                    next_up_tlp.data   = cpl_data;
                    give       = held;
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase

        // Reads longer than 4 KB or empty are taken and dropped, never sent.
        if (dma_rd_valid && dma_rd_ready && dma_rd_len != 11'h000
            && dma_rd_len <= MAX_RD_DW) begin
            next_up_valid      = 1'b1;
            next_up_tlp        = '0;
            next_up_tlp.kind   = K_MEM_RD;
            next_up_tlp.hdr4   = |dma_rd_addr[63:32];
            next_up_tlp.addr   = dma_rd_addr;
            next_up_tlp.len    = dma_rd_len;
            next_up_tlp.rid    = OWN_ID;
            next_up_tlp.tag    = dma_rd_tag;
        end
        for (int i = 0; i < FC_N; i++) begin
            next_fc_avail[i] = fc_avail[i] - take[i] + give[i];
        end
        // Keeping the DMA slot shut while a completion waits avoids a clash.
        next_dma_rd_ready = !next_up_valid && next_state != S_CPL;
        next_dn_ready     = next_state == S_IDLE;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state         <= S_IDLE;
            hold          <= '0;
            up_valid      <= 1'b0;
            up_tlp        <= '0;
            dn_ready      <= 1'b0;
            cpl_status    <= CPL_SC;
            cpl_data      <= '0;
            cpl_has_data  <= 1'b0;
            cli_valid     <= 1'b0;
            cli_dest      <= D_CFG;
            cli_kind      <= K_CFG_RD;
            cli_addr      <= '0;
            cli_wdata     <= '0;
            dma_rd_ready  <= 1'b0;
            dma_cpl_valid <= 1'b0;
            dma_cpl_tag   <= '0;
            dma_cpl_data  <= '0;
            dev_port_type <= DEV_TYPE_NATIVE;
            done_sync     <= '0;
            mps_sync      <= '0;
            for (int i = 0; i < FC_N; i++) begin
                fc_avail[i] <= (i % 2 == 0) ? HDR_CREDITS : DATA_CREDITS;
                held[i]     <= '0;
            end
        end else begin
            state         <= next_state;
            hold          <= next_hold;
            up_valid      <= next_up_valid;
            up_tlp        <= next_up_tlp;
            dn_ready      <= next_dn_ready;
            cpl_status    <= next_cpl_status;
            cpl_data      <= next_cpl_data;
            cpl_has_data  <= next_cpl_has_data;
            cli_valid     <= next_cli_valid;
            cli_dest      <= next_cli_dest;
            cli_kind      <= next_cli_kind;
            cli_addr      <= next_cli_addr;
            cli_wdata     <= next_cli_wdata;
            dma_rd_ready  <= next_dma_rd_ready;
            dma_cpl_valid <= next_dma_cpl_valid;
            dma_cpl_tag   <= next_dma_cpl_tag;
            dma_cpl_data  <= next_dma_cpl_data;
            dev_port_type <= next_dev_port_type;
            done_sync     <= {done_sync[0], nvm_done};
            mps_sync      <= {mps_sync[0], nvm_mps_256};
            for (int i = 0; i < FC_N; i++) begin
                fc_avail[i] <= next_fc_avail[i];
                held[i]     <= next_held[i];
            end
        end
    end

endmodule

// ### rtl/ptl_host_end.sv
`timescale 1ns/1ns
module ptl_host_end
    import ptl_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst_b,
    ptl_link_if.host       lnk,
    input  wire logic      host_mps_256,
    input  wire logic      req_valid,
    output logic           req_ready,
    input  wire ptl_tlp_t  req_tlp,
    output logic           req_err,
    output logic           rsp_valid,
    output ptl_tlp_t       rsp_tlp
);

    // ****************************************************************
    // Request and answer paths
    // ****************************************************************
    logic        dn_valid, next_dn_valid;
    ptl_tlp_t    dn_tlp, next_dn_tlp;
    logic        up_ready, next_up_ready;
    logic        next_req_ready, next_req_err, next_rsp_valid;
    ptl_tlp_t    next_rsp_tlp;
    logic        payload, rd, illegal;
    logic [10:0] mps_dw;

    assign lnk.dn_valid = dn_valid;
    assign lnk.dn_tlp   = dn_tlp;
    assign lnk.up_ready = up_ready;

    always_comb begin
        next_dn_valid  = dn_valid;
        next_dn_tlp    = dn_tlp;
        next_req_err   = 1'b0;
        next_rsp_valid = lnk.up_valid && up_ready;
        next_rsp_tlp   = rsp_tlp;
        next_up_ready  = 1'b1;
        mps_dw  = host_mps_256 ? MPS_LARGE_DW : MPS_SMALL_DW;
        payload = req_tlp.kind == K_MEM_WR || req_tlp.kind == K_CPLD
                  || req_tlp.kind == K_CFG_WR || req_tlp.kind == K_IO_WR;
        rd      = req_tlp.kind == K_MEM_RD || req_tlp.kind == K_MEM_RD_LK
                  || req_tlp.kind == K_IO_RD || req_tlp.kind == K_CFG_RD;
        illegal = (payload && req_tlp.len > mps_dw)
                  || (rd && req_tlp.len > MAX_RD_DW);
        if (lnk.up_valid && up_ready) next_rsp_tlp = lnk.up_tlp;
        if (dn_valid && lnk.dn_ready) next_dn_valid = 1'b0;
        if (req_valid && req_ready) begin
            if (illegal) begin
                next_req_err = 1'b1;
            end else begin
                next_dn_valid    = 1'b1;
                next_dn_tlp      = req_tlp;
                next_dn_tlp.hdr4 = |req_tlp.addr[63:32];
                next_dn_tlp.tc   = TC_ZERO;
                next_dn_tlp.td   = 1'b0;
            end
        end
        next_req_ready = !next_dn_valid;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dn_valid  <= 1'b0;
            dn_tlp    <= '0;
            up_ready  <= 1'b0;
            req_ready <= 1'b0;
            req_err   <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_tlp   <= '0;
        end else begin
            dn_valid  <= next_dn_valid;
            dn_tlp    <= next_dn_tlp;
            up_ready  <= next_up_ready;
            req_ready <= next_req_ready;
            req_err   <= next_req_err;
            rsp_valid <= next_rsp_valid;
            rsp_tlp   <= next_rsp_tlp;
        end
    end

endmodule

// ### rtl/ptl_link_if.sv
`timescale 1ns/1ns
interface ptl_link_if
    import ptl_pkg::*;
();
    logic     dn_valid;
    logic     dn_ready;
    ptl_tlp_t dn_tlp;
    logic     up_valid;
    logic     up_ready;
    ptl_tlp_t up_tlp;

    modport dev (
        input  dn_valid,
        output dn_ready,
        input  dn_tlp,
        output up_valid,
        input  up_ready,
        output up_tlp
    );

    modport host (
        output dn_valid,
        input  dn_ready,
        output dn_tlp,
        input  up_valid,
        output up_ready,
        input  up_tlp
    );
endinterface

// ### rtl/ptl_pkg.sv
package ptl_pkg;

    // ****************************************************************
    // Packet description
    // ****************************************************************
    typedef enum logic [3:0] {
        K_CFG_RD    = 4'h0,
        K_CFG_WR    = 4'h1,
        K_MEM_RD    = 4'h2,
        K_MEM_RD_LK = 4'h3,
        K_MEM_WR    = 4'h4,
        K_IO_RD     = 4'h5,
        K_IO_WR     = 4'h6,
        K_MSG       = 4'h7,
        K_CPL       = 4'h8,
        K_CPLD      = 4'h9
    } ptl_kind_t;

    // One beat carries the whole header and at most one dword of data.
    typedef struct packed {
        ptl_kind_t   kind;
        logic        hdr4;
        logic [63:0] addr;
        logic [10:0] len;
        logic [15:0] rid;
        logic [7:0]  tag;
        logic [1:0]  attr;
        logic [2:0]  tc;
        logic        td;
        logic [2:0]  status;
        logic [7:0]  code;
        logic [31:0] data;
    } ptl_tlp_t;

    typedef enum logic [1:0] {
        D_CFG = 2'h0,
        D_CSR = 2'h1,
        D_MSG = 2'h2
    } ptl_dest_t;

    typedef enum logic [3:0] {
        S_IDLE   = 4'h1,
        S_CHECK  = 4'h2,
        S_CLIENT = 4'h4,
        S_CPL    = 4'h8
    } ptl_state_t;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam logic [2:0]  CPL_SC          = 3'h0;
    localparam logic [2:0]  CPL_UR          = 3'h1;
    localparam logic [2:0]  CPL_CRS         = 3'h2;
    localparam logic [3:0]  DEV_TYPE_NATIVE = 4'h0;
    localparam logic [2:0]  TC_ZERO         = 3'h0;
    localparam int          DW_BYTES        = 4;
    localparam int          MPS_SMALL_BYTES = 128;
    localparam int          MPS_LARGE_BYTES = 256;
    localparam int          MAX_RD_BYTES    = 4096;
    localparam logic [10:0] MPS_SMALL_DW    = 11'(MPS_SMALL_BYTES / DW_BYTES);
    localparam logic [10:0] MPS_LARGE_DW    = 11'(MPS_LARGE_BYTES / DW_BYTES);
    localparam logic [10:0] MAX_RD_DW       = 11'(MAX_RD_BYTES / DW_BYTES);
    localparam logic [10:0] DW_PER_CREDIT_M1 = 11'h003;
    localparam int          FC_PH           = 0;
    localparam int          FC_PD           = 1;
    localparam int          FC_NPH          = 2;
    localparam int          FC_NPD          = 3;
    localparam int          FC_CPLH         = 4;
    localparam int          FC_CPLD         = 5;
    localparam int          FC_N            = 6;
    localparam logic [9:0]  HDR_CREDIT_DEF  = 10'h008;
    localparam logic [9:0]  DATA_CREDIT_DEF = 10'h040;
    localparam logic [9:0]  ONE_CREDIT      = 10'h001;

endpackage

// ### verif/pcie_transaction_layer_rx_tb.sv
`timescale 1ns/1ns
module pcie_transaction_layer_rx_tb
    import ptl_pkg::*;
;
    localparam logic [31:0] CLI_RD = 32'hA5C3_0F1E;
    logic        core_clk, rst_b, nvm_done, req_valid, cli_ack, dma_rd_valid, mps_big;
    logic [10:0] dma_len;
    logic        req_ready, req_err, rsp_valid, cli_valid, dma_rd_ready, dma_cpl_valid;
    logic [3:0]  dev_port_type;
    logic [63:0] dma_rd_addr, cli_addr;
    logic [7:0]  dma_rd_tag, dma_cpl_tag, dtag;
    logic [31:0] cli_wdata, dma_cpl_data, cwd, ddat;
    ptl_tlp_t    req_tlp, rsp_tlp, got;
    ptl_dest_t   cli_dest, cdest;
    ptl_kind_t   cli_kind;
    int          num_errors, n_compared, rsp_cnt, ack_cnt, dma_cnt, err_cnt;

    ptl_link_if lnk ();
    ptl_dev_end i_ptl_dev_end (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk),
        .nvm_done(nvm_done), .nvm_mps_256(mps_big), .cfg_mps_256(1'b1),
        .dev_port_type(dev_port_type), .cli_valid(cli_valid), .cli_ack(cli_ack),
        .cli_dest(cli_dest), .cli_kind(cli_kind), .cli_addr(cli_addr), .cli_wdata(cli_wdata),
        .cli_rdata(CLI_RD), .dma_rd_valid(dma_rd_valid), .dma_rd_ready(dma_rd_ready),
        .dma_rd_addr(dma_rd_addr), .dma_rd_len(dma_len), .dma_rd_tag(dma_rd_tag),
        .dma_cpl_valid(dma_cpl_valid), .dma_cpl_tag(dma_cpl_tag), .dma_cpl_data(dma_cpl_data));
    ptl_host_end i_ptl_host_end (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk),
        .host_mps_256(mps_big), .req_valid(req_valid), .req_ready(req_ready), .req_tlp(req_tlp),
        .req_err(req_err), .rsp_valid(rsp_valid), .rsp_tlp(rsp_tlp));
    ptl_link_assertions i_chk (.core_clk(core_clk), .rst_b(rst_b), .dn_valid(lnk.dn_valid),
        .dn_ready(lnk.dn_ready), .dn_tlp(lnk.dn_tlp), .up_valid(lnk.up_valid),
        .up_ready(lnk.up_ready), .up_tlp(lnk.up_tlp));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Pulses are captured at the edge that samples them; the client acks one cycle late.
    always @(posedge core_clk) begin
        if (rsp_valid) begin got = rsp_tlp; rsp_cnt++; end
        if (req_err) err_cnt++;
        if (dma_cpl_valid) begin dtag = dma_cpl_tag; ddat = dma_cpl_data; dma_cnt++; end
        if (cli_valid && cli_ack) begin cdest = cli_dest; cwd = cli_wdata; ack_cnt++; end
        #1 cli_ack = cli_valid && !cli_ack;
    end

    task automatic cmp(string n, logic [63:0] e, logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic ptl_tlp_t mk(ptl_kind_t k, logic [63:0] a);
        ptl_tlp_t t;
        t = '0; t.kind = k; t.addr = a; t.len = 11'h001; t.rid = 16'h0ABC;
        t.tag = 8'h5A; t.attr = 2'h2; t.data = 32'h1234_5678; t.code = 8'h19;
        return t;
    endfunction

    task automatic send(ptl_tlp_t t);
        int i;
        @(posedge core_clk);
        #1 req_valid = 1'b1;
        req_tlp = t;
        i = 0;
        do begin @(posedge core_clk); i++; end while (!req_ready && i < 50);
        cmp("req_ready", 1, req_ready);
        #1 req_valid = 1'b0;
    endtask

    task automatic xact(ptl_kind_t sk, logic w, ptl_kind_t k, logic [2:0] st, logic cl,
                        ptl_dest_t d);
        int n0, a0, i;
        n0 = rsp_cnt; a0 = ack_cnt;
        send(mk(sk, 64'h0000_0000_0000_0040));
        for (i = 0; i < 40 && rsp_cnt == n0; i++) @(posedge core_clk);
        cmp("rsp_count", w, rsp_cnt - n0);
        cmp("client_count", cl, ack_cnt - a0);
        if (w) begin
            cmp("kind", k, got.kind); cmp("status", st, got.status);
            cmp("rid", 16'h0ABC, got.rid); cmp("tag", 8'h5A, got.tag); cmp("attr", 2'h2, got.attr);
        end
        if (cl) cmp("dest", d, cdest);
    endtask

    task automatic t_config;
        xact(K_CFG_RD, 1, K_CPL, CPL_CRS, 0, D_CFG);
        #1 nvm_done = 1'b1;
        repeat (4) @(posedge core_clk);
        xact(K_CFG_RD, 1, K_CPLD, CPL_SC, 1, D_CFG);
        cmp("cpl_data", CLI_RD, got.data);
        xact(K_CFG_WR, 1, K_CPL, CPL_SC, 1, D_CFG);
    endtask

    task automatic t_csr;
        xact(K_MEM_RD, 1, K_CPLD, CPL_SC, 1, D_CSR);
        xact(K_IO_RD, 1, K_CPLD, CPL_SC, 1, D_CSR);
        xact(K_IO_WR, 1, K_CPL, CPL_SC, 1, D_CSR);
        xact(K_MEM_RD_LK, 1, K_CPL, CPL_UR, 0, D_CSR);
        xact(K_MEM_WR, 0, K_CPL, CPL_SC, 1, D_CSR);
        cmp("wdata", 32'h1234_5678, cwd);
        xact(K_MSG, 0, K_CPL, CPL_SC, 1, D_MSG);
        cmp("msg_code", 8'h19, cwd[7:0]);
    endtask

    task automatic t_dma(logic [63:0] a, logic h4);
        int n0, d0, i;
        n0 = rsp_cnt; d0 = dma_cnt;
        @(posedge core_clk);
        #1 dma_rd_valid = 1'b1;
        dma_rd_addr = a; dma_rd_tag = 8'h5A;
        i = 0;
        do begin @(posedge core_clk); i++; end while (!dma_rd_ready && i < 50);
        cmp("rd_ready", 1, dma_rd_ready);
        #1 dma_rd_valid = 1'b0;
        for (i = 0; i < 40 && rsp_cnt == n0; i++) @(posedge core_clk);
        cmp("rd_kind", K_MEM_RD, got.kind); cmp("rd_hdr4", h4, got.hdr4);
        cmp("rd_addr", a, got.addr); cmp("rd_tag", 8'h5A, got.tag);
        send(mk(K_CPLD, 64'h0));
        for (i = 0; i < 40 && dma_cnt == d0; i++) @(posedge core_clk);
        cmp("cpl_count", d0 + 1, dma_cnt);
        cmp("cpl_tag", 8'h5A, dtag); cmp("cpl_dat", 32'h1234_5678, ddat);
        cmp("cpl_quiet", n0 + 1, rsp_cnt);
    endtask

    task automatic t_limits;
        ptl_tlp_t t;
        int e0;
        e0 = err_cnt;
        t = mk(K_MEM_WR, 64'h100); t.len = 11'h021; send(t);
        t.kind = K_MEM_RD; t.len = 11'h401; send(t);
        repeat (3) @(posedge core_clk);
        cmp("req_err_count", 2, err_cnt - e0);
    endtask

    // Both ends support 256 bytes and config selects it, so 33 dwords pass.
    task automatic t_mps;
        ptl_tlp_t t;
        int a0, i;
        #1 mps_big = 1'b1;
        repeat (3) @(posedge core_clk);
        a0 = ack_cnt;
        t = mk(K_MEM_WR, 64'h100); t.len = 11'h021; send(t);
        for (i = 0; i < 40 && ack_cnt == a0; i++) @(posedge core_clk);
        cmp("mps_256_accept", a0 + 1, ack_cnt);
    endtask

    task automatic t_dma_big;
        int n0;
        n0 = rsp_cnt;
        @(posedge core_clk);
        #1 dma_rd_valid = 1'b1;
        dma_len = 11'h401;
        @(posedge core_clk);
        cmp("big_rd_ready", 1, dma_rd_ready);
        #1 dma_rd_valid = 1'b0;
        dma_len = 11'h001;
        repeat (10) @(posedge core_clk);
        cmp("big_rd_quiet", n0, rsp_cnt);
    endtask

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        $display("MISMATCH watchdog expected done seen hang");
        summarize;
    end

    initial begin
        rst_b = 1'b0; nvm_done = 1'b0; req_valid = 1'b0; req_tlp = '0; cli_ack = 1'b0;
        dma_rd_valid = 1'b0; dma_rd_addr = '0; dma_rd_tag = '0;
        mps_big = 1'b0; dma_len = 11'h001;
        repeat (5) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge core_clk);
        cmp("dev_port_type", DEV_TYPE_NATIVE, dev_port_type);
        t_config;
        t_csr;
        t_dma(64'h0000_0000_0000_1000, 1'b0);
        t_dma(64'h0000_0001_0000_0000, 1'b1);
        t_limits;
        t_mps;
        t_dma_big;
        summarize;
    end
endmodule

// ### verif/ptl_link_assertions.sv
`timescale 1ns/1ns
module ptl_link_assertions
    import ptl_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     rst_b,
    input wire logic     dn_valid,
    input wire logic     dn_ready,
    input wire ptl_tlp_t dn_tlp,
    input wire logic     up_valid,
    input wire logic     up_ready,
    input wire ptl_tlp_t up_tlp
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    wire logic dn_take = dn_valid && dn_ready;
    wire logic up_rd   = up_valid && up_tlp.kind == K_MEM_RD;

    chk_dn_hold: assert property (dn_valid && !dn_ready |=> dn_valid && $stable(dn_tlp))
        else $error("downstream packet changed before it was taken");
    chk_up_hold: assert property (up_valid && !up_ready |=> up_valid && $stable(up_tlp))
        else $error("upstream packet changed before it was taken");
    chk_no_lock: assert property (up_valid |-> up_tlp.kind != K_MEM_RD_LK)
        else $error("locked read issued upstream");
    chk_no_digest: assert property (up_valid |-> !up_tlp.td)
        else $error("digest flag set upstream");
    chk_tc_zero: assert property (up_valid |-> up_tlp.tc == TC_ZERO)
        else $error("nonzero traffic class upstream");
    chk_rd_size: assert property (up_rd |-> up_tlp.len <= MAX_RD_DW && up_tlp.len != 11'h000)
        else $error("read request size out of range");
    chk_hdr_short: assert property (up_rd && up_tlp.addr[63:32] == 32'h0 |-> !up_tlp.hdr4)
        else $error("long header used below 4 GB");
    chk_hdr_long: assert property (up_rd && |up_tlp.addr[63:32] |-> up_tlp.hdr4)
        else $error("short header used above 4 GB");
    chk_rd_answer: assert property (dn_take && dn_tlp.kind inside {K_CFG_RD, K_MEM_RD, K_IO_RD}
        |-> ##[3:60] up_valid && (up_tlp.kind == K_CPLD || up_tlp.status != CPL_SC))
        else $error("read not answered with data");
    chk_wr_answer: assert property (dn_take && dn_tlp.kind inside {K_CFG_WR, K_IO_WR}
        |-> ##[3:60] up_valid && up_tlp.kind == K_CPL)
        else $error("write not answered with header only");
    chk_posted_quiet: assert property (dn_take && dn_tlp.kind inside {K_MEM_WR, K_MSG, K_CPLD}
        |=> !up_valid [*4])
        else $error("answer sent for posted or completion packet");
    chk_payload: assert property (dn_take && dn_tlp.kind == K_MEM_WR |-> dn_tlp.len <= MPS_LARGE_DW)
        else $error("payload above limit sent downstream");
endmodule
